// *** design/fa_pkg.sv ***
/*
 * constants and types shared by the flash access register file.
 * assumes one core clock domain and byte wide special function accesses.
 */
package fa_pkg;

  // register offsets within the bank that decodes them
  localparam logic [7:0] OFS_ADDR_LOW = 8'h40;
  localparam logic [7:0] OFS_WORD_LOW_BASE = 8'h41;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h40;
  localparam logic [7:0] OFS_WORD_HIGH_BASE = 8'h41;
  localparam logic [7:0] OFS_OP_CTRL = 8'h45;
  localparam logic [7:0] OFS_AUX_CTRL = 8'h46;

  // bank numbers
  localparam logic BANK_LOW = 1'b0;
  localparam logic BANK_HIGH = 1'b1;

  // sizes
  localparam int WORDS = 4;
  localparam int PAGE_WORDS = 32;
  localparam logic [4:0] PAGE_LAST = 5'h1f;
  localparam int ADDR_HIGH_BITS = 4;

  // operation control field positions
  localparam int CTL_RD_TRIG = 0;
  localparam int CTL_RD_EN = 1;
  localparam int CTL_WR_TRIG = 2;
  localparam int CTL_MODE_TRIG = 3;
  localparam int CTL_MODE_LSB = 4;
  localparam int CTL_WR_EN_FLAG = 7;

  // aux control field positions
  localparam int AUX_BUF_CLEAR = 0;
  localparam int AUX_SW_RESET = 4;

  // reset and fill values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [11:0] ADDR_RESET = 12'h000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] BUF_FILL = 16'hffff;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // register file state
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] ctrl;
    logic sw_reset;
    logic buf_clear;
    logic wr_invalid;
    logic [31:0][15:0] wbuf;
    logic [15:0] wbuf_q;
    logic [7:0] rdata;
    logic rd_go;
    logic wr_go;
    logic mode_go;
  } fa_regs_s;

  // one flash data word
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } fa_word_s;

endpackage : fa_pkg

// *** design/fa_data_word.sv ***
/*
 * one 16-bit flash data word held as a low and a high byte register.
 * assumes the parent decodes the byte write strobes.
 */
`timescale 1ns/1ps
module fa_data_word (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic low_we_i,
  input wire logic high_we_i,
  input wire logic [7:0] wdata_i,
  input wire logic load_i,
  input wire logic [15:0] load_data_i,
  output logic [15:0] word_o
);

  fa_pkg::fa_word_s q;
  fa_pkg::fa_word_s next_q;

  // byte writes, whole word load from a flash read
  always_comb begin
    next_q = q;
    if (load_i) begin
      next_q = fa_pkg::fa_word_s'(load_data_i);
    end
    if (low_we_i) begin
      next_q.low = wdata_i;
    end
    if (high_we_i) begin
      next_q.high = wdata_i;
    end
  end

  // content is meaningless until written; zero for clean simulation
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= fa_pkg::fa_word_s'(fa_pkg::WORD_RESET);
    end else begin
      q <= next_q;
    end
  end

  assign word_o = q;

endmodule : fa_data_word

// *** design/fa_flash_regs.sv ***
/*
 * flash access register file: address, data words, control registers,
 * page write buffer, the start strobes to and the done strobes from the flash sequencer.
 * assumes the core presents one byte access per cycle with bank and
 * indirect flags, and a sequencer that pulses done when work ends.
 */
`timescale 1ns/1ps
module fa_flash_regs (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_bank_i,
  input wire logic sfr_indirect_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic mode_done_i,
  input wire logic write_done_i,
  input wire logic read_done_i,
  input wire logic [15:0] read_data_i,
  input wire logic [4:0] wbuf_idx_i,
  output logic [15:0] wbuf_data_o,
  output logic [11:0] flash_addr_o,
  output logic [2:0] flash_op_mode_o,
  output logic flash_write_enable_flag_o,
  output logic mode_change_start_o,
  output logic write_cycle_start_o,
  output logic read_cycle_start_o,
  output logic software_core_reset_o
);

  fa_pkg::fa_regs_s q;
  fa_pkg::fa_regs_s next_q;

  logic [3:0] low_we;
  logic [3:0] high_we;
  logic [3:0][15:0] words;
  logic [3:0][7:0] low_sel;
  logic [3:0][7:0] high_sel;
  logic sel_addr_low;
  logic sel_addr_high;
  logic sel_ctrl;
  logic sel_aux;
  logic high_ok;
  logic w0_high_wr;

  // bank 0 registers take direct or indirect access; bank 1 only indirect
  assign high_ok = (sfr_bank_i == fa_pkg::BANK_HIGH) && sfr_indirect_i;
  assign sel_addr_low = (sfr_bank_i == fa_pkg::BANK_LOW)
    && (sfr_addr_i == fa_pkg::OFS_ADDR_LOW);
  assign sel_addr_high = high_ok && (sfr_addr_i == fa_pkg::OFS_ADDR_HIGH);
  assign sel_ctrl = high_ok && (sfr_addr_i == fa_pkg::OFS_OP_CTRL);
  assign sel_aux = high_ok && (sfr_addr_i == fa_pkg::OFS_AUX_CTRL);

  // byte strobes for the four data words, word 0 first
  genvar gi;
  generate
    for (gi = 0; gi < fa_pkg::WORDS; gi++) begin : g_word
      assign low_sel[gi] = fa_pkg::OFS_WORD_LOW_BASE + 8'(gi);
      assign high_sel[gi] = fa_pkg::OFS_WORD_HIGH_BASE + 8'(gi);
      assign low_we[gi] = sfr_wr_i && (sfr_bank_i == fa_pkg::BANK_LOW)
        && (sfr_addr_i == low_sel[gi]);
      assign high_we[gi] = sfr_wr_i && high_ok
        && (sfr_addr_i == high_sel[gi]);
      fa_data_word u_word (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .low_we_i(low_we[gi]),
        .high_we_i(high_we[gi]),
        .wdata_i(sfr_wdata_i),
        .load_i(read_done_i && (gi == 0)),
        .load_data_i(read_data_i),
        .word_o(words[gi])
      );
    end
  endgenerate

  assign w0_high_wr = high_we[0];

  // next state of the register file
  always_comb begin
    next_q = q;
    next_q.rd_go = 1'b0;
    next_q.wr_go = 1'b0;
    next_q.mode_go = 1'b0;
    next_q.wbuf_q = q.wbuf[wbuf_idx_i];
    // address bytes; loading either one revalidates buffered writes
    if (sfr_wr_i && sel_addr_low) begin
      next_q.addr[7:0] = sfr_wdata_i;
      next_q.wr_invalid = 1'b0;
    end
    if (sfr_wr_i && sel_addr_high) begin
      next_q.addr[11:8] = sfr_wdata_i[fa_pkg::ADDR_HIGH_BITS-1:0];
      next_q.wr_invalid = 1'b0;
    end
    // word 0 high write pushes the whole word into the page buffer
    if (w0_high_wr && !q.wr_invalid) begin
      next_q.wbuf[q.addr[4:0]] = {sfr_wdata_i, words[0][7:0]};
      if (q.addr[4:0] == fa_pkg::PAGE_LAST) begin
        next_q.wr_invalid = 1'b1;
      end else begin
        next_q.addr = q.addr + 12'h001;
      end
    end
    // hardware ends triggered cycles
    if (mode_done_i) begin
      next_q.ctrl[fa_pkg::CTL_MODE_TRIG] = 1'b0;
    end
    if (write_done_i) begin
      next_q.ctrl[fa_pkg::CTL_WR_TRIG] = 1'b0;
    end
    if (read_done_i) begin
      next_q.ctrl[fa_pkg::CTL_RD_TRIG] = 1'b0;
    end
    // software control write; a trigger bit still set refuses a new set, so a same-cycle done wins
    if (sfr_wr_i && sel_ctrl) begin
      next_q.ctrl[7:4] = sfr_wdata_i[7:4];
      next_q.ctrl[fa_pkg::CTL_RD_EN] = sfr_wdata_i[fa_pkg::CTL_RD_EN];
      if (sfr_wdata_i[fa_pkg::CTL_MODE_TRIG]
          && !q.ctrl[fa_pkg::CTL_MODE_TRIG]) begin
        next_q.ctrl[fa_pkg::CTL_MODE_TRIG] = 1'b1;
        next_q.mode_go = 1'b1;
      end
      if (sfr_wdata_i[fa_pkg::CTL_WR_TRIG]
          && !q.ctrl[fa_pkg::CTL_WR_TRIG]) begin
        next_q.ctrl[fa_pkg::CTL_WR_TRIG] = 1'b1;
        next_q.wr_go = 1'b1;
      end
      // read trigger needs the read enable, old or newly written
      if (sfr_wdata_i[fa_pkg::CTL_RD_TRIG]
          && !q.ctrl[fa_pkg::CTL_RD_TRIG]
          && (q.ctrl[fa_pkg::CTL_RD_EN]
              || sfr_wdata_i[fa_pkg::CTL_RD_EN])) begin
        next_q.ctrl[fa_pkg::CTL_RD_TRIG] = 1'b1;
        next_q.rd_go = 1'b1;
      end
    end
    // buffer clear completes in one cycle, then hardware drops the bit
    if (q.buf_clear) begin
      for (int i = 0; i < fa_pkg::PAGE_WORDS; i++) begin
        next_q.wbuf[i] = fa_pkg::BUF_FILL;
      end
      next_q.buf_clear = 1'b0;
    end
    // a write end asks for a buffer clear, also in the clearing cycle, where it asks for one more
    if (write_done_i) begin
      next_q.buf_clear = 1'b1;
    end
    // aux control: only the two implemented bits store
    if (sfr_wr_i && sel_aux) begin
      next_q.sw_reset = sfr_wdata_i[fa_pkg::AUX_SW_RESET];
      if (sfr_wdata_i[fa_pkg::AUX_BUF_CLEAR]) begin
        next_q.buf_clear = 1'b1;
      end
    end
    // registered read answer, zero for anything not decoded
    next_q.rdata = fa_pkg::READ_ZERO;
    if (sfr_rd_i) begin
      if (sel_addr_low) begin
        next_q.rdata = q.addr[7:0];
      end else if (sel_addr_high) begin
        next_q.rdata = {4'h0, q.addr[11:8]};
      end else if (sel_ctrl) begin
        next_q.rdata = q.ctrl;
      end else if (sel_aux) begin
        next_q.rdata = {3'h0, q.sw_reset, 3'h0, q.buf_clear};
      end else begin
        for (int i = 0; i < fa_pkg::WORDS; i++) begin
          if ((sfr_bank_i == fa_pkg::BANK_LOW)
              && (sfr_addr_i == low_sel[i])) begin
            next_q.rdata = words[i][7:0];
          end
          if (high_ok && (sfr_addr_i == high_sel[i])) begin
            next_q.rdata = words[i][15:8];
          end
        end
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
      q.addr <= fa_pkg::ADDR_RESET;
      q.ctrl <= fa_pkg::CTRL_RESET;
    end else begin
      q <= next_q;
    end
  end

  // outputs to core and sequencer
  assign sfr_rdata_o = q.rdata;
  assign wbuf_data_o = q.wbuf_q;
  assign flash_addr_o = q.addr;
  assign flash_op_mode_o = q.ctrl[fa_pkg::CTL_MODE_LSB +: 3];
  assign flash_write_enable_flag_o = q.ctrl[fa_pkg::CTL_WR_EN_FLAG];
  assign mode_change_start_o = q.mode_go;
  assign write_cycle_start_o = q.wr_go;
  assign read_cycle_start_o = q.rd_go;
  assign software_core_reset_o = q.sw_reset;

  // checks on the register file
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  property p_addr_high_zero;
    sfr_rd_i && sel_addr_high |=> sfr_rdata_o[7:4] == 4'h0;
  endproperty
  a_addr_high_zero: assert property (p_addr_high_zero)
    else $error("address high upper bits not zero");

  property p_addr_low_load;
    sfr_wr_i && sel_addr_low |=> flash_addr_o[7:0] == $past(sfr_wdata_i);
  endproperty
  a_addr_low_load: assert property (p_addr_low_load)
    else $error("address low not loaded");

  property p_direct_high_ignored;
    sfr_wr_i && !sfr_indirect_i && sfr_bank_i == fa_pkg::BANK_HIGH
      && !w0_high_wr && !read_done_i
      |=> $stable(words) && $stable(q.ctrl[7:4]);
  endproperty
  a_direct_high_ignored: assert property (p_direct_high_ignored)
    else $error("direct access changed a bank 1 register");

  property p_addr_incr;
    w0_high_wr && !q.wr_invalid && q.addr[4:0] != fa_pkg::PAGE_LAST
      |=> flash_addr_o == $past(flash_addr_o) + 12'h001;
  endproperty
  a_addr_incr: assert property (p_addr_incr)
    else $error("address did not step after word 0 high write");

  property p_page_stop;
    w0_high_wr && q.addr[4:0] == fa_pkg::PAGE_LAST
      |=> $stable(flash_addr_o) && q.wr_invalid;
  endproperty
  a_page_stop: assert property (p_page_stop)
    else $error("address passed the page end");

  property p_clear_ends;
    q.buf_clear && !(sfr_wr_i && sel_aux) && !write_done_i
      |=> !q.buf_clear ##0 q.wbuf[0] == fa_pkg::BUF_FILL;
  endproperty
  a_clear_ends: assert property (p_clear_ends)
    else $error("buffer clear did not complete");

  property p_read_needs_enable;
    read_cycle_start_o |-> $past(q.ctrl[fa_pkg::CTL_RD_EN])
      || q.ctrl[fa_pkg::CTL_RD_EN];
  endproperty
  a_read_needs_enable: assert property (p_read_needs_enable)
    else $error("read started without read enable");

  property p_read_loads_word0;
    read_done_i && !low_we[0] && !high_we[0]
      |=> words[0] == $past(read_data_i);
  endproperty
  a_read_loads_word0: assert property (p_read_loads_word0)
    else $error("read data not placed in word 0");

  property p_buffer_store;
    w0_high_wr && !q.wr_invalid && !q.buf_clear
      |=> q.wbuf[$past(q.addr[4:0])]
        == {$past(sfr_wdata_i), $past(words[0][7:0])};
  endproperty
  a_buffer_store: assert property (p_buffer_store)
    else $error("word not stored in write buffer");

  property p_word_low_direct;
    sfr_wr_i && !sfr_indirect_i && sfr_bank_i == fa_pkg::BANK_LOW
      && sfr_addr_i == fa_pkg::OFS_WORD_LOW_BASE && !read_done_i
      |=> words[0][7:0] == $past(sfr_wdata_i);
  endproperty
  a_word_low_direct: assert property (p_word_low_direct)
    else $error("direct write missed word 0 low");

  property p_word3_high_indirect;
    sfr_wr_i && sfr_indirect_i && sfr_bank_i == fa_pkg::BANK_HIGH
      && sfr_addr_i == fa_pkg::OFS_WORD_HIGH_BASE + 8'h03
      |=> words[3][15:8] == $past(sfr_wdata_i);
  endproperty
  a_word3_high_indirect: assert property (p_word3_high_indirect)
    else $error("indirect write missed word 3 high");

  property p_stuck_drop;
    w0_high_wr && q.wr_invalid && !q.buf_clear
      |=> $stable(q.wbuf) && $stable(flash_addr_o);
  endproperty
  a_stuck_drop: assert property (p_stuck_drop)
    else $error("write past the page end was not dropped");

  property p_clear_set;
    sfr_wr_i && sel_aux && sfr_wdata_i[fa_pkg::AUX_BUF_CLEAR]
      |=> q.buf_clear;
  endproperty
  a_clear_set: assert property (p_clear_set)
    else $error("buffer clear request not taken");

endmodule : fa_flash_regs

// *** test/fa_tb.sv ***
/*
 * self-checking bench for the flash access register file.
 * assumes the design files are compiled first; bench drives every port.
 */
`timescale 1ns/1ps
module testbench;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic sfr_bank_i = 1'b0;
  logic sfr_indirect_i = 1'b0;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic mode_done_i = 1'b0;
  logic write_done_i = 1'b0;
  logic read_done_i = 1'b0;
  logic [15:0] read_data_i = 16'h0000;
  logic [4:0] wbuf_idx_i = 5'h00;
  logic [7:0] sfr_rdata_o;
  logic [15:0] wbuf_data_o;
  logic [11:0] flash_addr_o;
  logic [2:0] flash_op_mode_o;
  logic flash_write_enable_flag_o;
  logic mode_change_start_o;
  logic write_cycle_start_o;
  logic read_cycle_start_o;
  logic software_core_reset_o;
  logic [7:0] rv;
  int fail_count = 0;
  int check_count = 0;
  int seed = 96875;
  int mdl [int]; // register images keyed by bank*256+offset
  int mbuf [32]; // write buffer image
  int stuck = 0; // address parked on the last word of a page

  fa_flash_regs i_fa_flash_regs (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .sfr_addr_i(sfr_addr_i), .sfr_bank_i(sfr_bank_i),
    .sfr_indirect_i(sfr_indirect_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .mode_done_i(mode_done_i),
    .write_done_i(write_done_i), .read_done_i(read_done_i),
    .read_data_i(read_data_i), .wbuf_idx_i(wbuf_idx_i),
    .wbuf_data_o(wbuf_data_o), .flash_addr_o(flash_addr_o),
    .flash_op_mode_o(flash_op_mode_o),
    .flash_write_enable_flag_o(flash_write_enable_flag_o),
    .mode_change_start_o(mode_change_start_o),
    .write_cycle_start_o(write_cycle_start_o),
    .read_cycle_start_o(read_cycle_start_o),
    .software_core_reset_o(software_core_reset_o));

  // core clock, 10 ns period
  always #5 ref_clk_i = ~ref_clk_i;

  // compare tasks
  task automatic chk_reg(string nm, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_reg

  task automatic chk_out(string nm, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_out

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // one byte write, then the model follows it
  task automatic wr(input logic b, input logic ind, input logic [7:0] a,
                    input logic [7:0] d);
    int k;
    int ad;
    @(posedge ref_clk_i);
    sfr_bank_i <= b;
    sfr_indirect_i <= ind;
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    sfr_wr_i <= 1'b0;
    k = b * 256 + a;
    if ((b && !ind) || !mdl.exists(k)) return;
    mdl[k] = (k == 'h140) ? d & 'h0f : (k == 'h146) ? d & 'h10 : d;
    if (k == 'h040 || k == 'h140) stuck = 0;
    if (k == 'h141 && stuck == 0) begin
      ad = mdl['h140] * 256 + mdl['h040];
      mbuf[ad % 32] = d * 256 + mdl['h041];
      if (ad % 32 == 31) stuck = 1;
      else ad = ad + 1;
      mdl['h040] = ad % 256;
      mdl['h140] = ad / 256;
    end
  endtask : wr

  task automatic rd(input logic b, input logic ind, input logic [7:0] a);
    @(posedge ref_clk_i);
    sfr_bank_i <= b;
    sfr_indirect_i <= ind;
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    sfr_rd_i <= 1'b0;
    #1;
    rv = sfr_rdata_o;
  endtask : rd

  task automatic rd_chk(input logic b, input logic ind, input logic [7:0] a);
    int k;
    k = b * 256 + a;
    rd(b, ind, a);
    chk_reg("sfr_rdata_o", ((ind || !b) && mdl.exists(k)) ?
            8'(mdl[k]) : 8'h00, rv);
  endtask : rd_chk

  task automatic chk_addr;
    #1;
    chk_out("flash_addr_o", 16'(mdl['h140] * 256 + mdl['h040]),
            16'(flash_addr_o));
  endtask : chk_addr

  task automatic bufchk(input logic [4:0] i);
    @(posedge ref_clk_i);
    wbuf_idx_i <= i;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk_out("wbuf_data_o", 16'(mbuf[i]), wbuf_data_o);
  endtask : bufchk

  task automatic wait_aux_clear;
    int n;
    n = 0;
    rd(1'b1, 1'b1, 8'h46);
    while (rv[0] !== 1'b0 && n < 8) begin
      rd(1'b1, 1'b1, 8'h46);
      n++;
    end
    if (rv[0] !== 1'b0) begin
      fail_count++;
      $display("[FAIL] buffer clear bit expected 0 seen 1");
      tally_and_finish();
    end
  endtask : wait_aux_clear

  // hang guard
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    fail_count++;
    $display("[FAIL] run time expected end seen hang");
    tally_and_finish();
  end

  // main sequence
  initial begin
    for (int i = 0; i < 5; i++) begin
      mdl['h040 + i] = 0;
      mdl['h140 + i] = 0;
    end
    mdl['h146] = 0;
    repeat (4) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    chk_addr();
    // random bytes, direct, indirect and refused direct bank 1 writes
    for (int i = 0; i < 5; i++) begin
      wr(1'b0, 1'b0, 8'h40 + 8'(i), 8'($random(seed)));
      wr(1'b1, 1'b1, 8'h40 + 8'(i), 8'($random(seed)));
      wr(1'b1, 1'b0, 8'h40 + 8'(i), 8'($random(seed)));
    end
    chk_addr();
    for (int i = 0; i < 5; i++) begin
      rd_chk(1'b0, 1'b0, 8'h40 + 8'(i));
      rd_chk(1'b1, 1'b1, 8'h40 + 8'(i));
      rd_chk(1'b1, 1'b0, 8'h40 + 8'(i));
    end
    rd_chk(1'b0, 1'b0, 8'h45);
    rd_chk(1'b1, 1'b0, 8'h45);
    $display("test byte registers done");
    // buffered writes walking onto the last word of a page
    wr(1'b0, 1'b0, 8'h40, 8'h1e);
    wr(1'b1, 1'b1, 8'h40, 8'h02);
    wr(1'b0, 1'b0, 8'h41, 8'($random(seed)));
    for (int i = 0; i < 3; i++) begin
      wr(1'b1, 1'b1, 8'h41, 8'($random(seed)));
      chk_addr();
    end
    bufchk(5'h1e);
    rd_chk(1'b0, 1'b0, 8'h40);
    wr(1'b0, 1'b0, 8'h40, 8'h00);
    wr(1'b1, 1'b1, 8'h41, 8'($random(seed)));
    bufchk(5'h00);
    chk_addr();
    $display("test page walk done");
    // read trigger refused, then accepted with enable
    wr(1'b1, 1'b1, 8'h45, 8'h01);
    #1;
    chk_out("read_cycle_start_o", 16'h0000, 16'(read_cycle_start_o));
    wr(1'b1, 1'b1, 8'h45, 8'h03);
    #1;
    chk_out("read_cycle_start_o", 16'h0001, 16'(read_cycle_start_o));
    @(posedge ref_clk_i);
    read_data_i <= 16'($random(seed));
    read_done_i <= 1'b1;
    @(posedge ref_clk_i);
    read_done_i <= 1'b0;
    mdl['h041] = read_data_i[7:0];
    mdl['h141] = read_data_i[15:8];
    rd_chk(1'b0, 1'b0, 8'h41);
    rd_chk(1'b1, 1'b1, 8'h41);
    rd(1'b1, 1'b1, 8'h45);
    chk_reg("op control", 8'h02, rv);
    $display("test word read done");
    // write cycle, buffer cleared afterwards
    wr(1'b1, 1'b1, 8'h45, 8'h06);
    #1;
    chk_out("write_cycle_start_o", 16'h1, 16'(write_cycle_start_o));
    @(posedge ref_clk_i);
    write_done_i <= 1'b1;
    @(posedge ref_clk_i);
    write_done_i <= 1'b0;
    wait_aux_clear();
    foreach (mbuf[i]) mbuf[i] = 'hffff;
    bufchk(5'h1e);
    rd(1'b1, 1'b1, 8'h45);
    chk_reg("op control", 8'h02, rv);
    wr(1'b1, 1'b1, 8'h46, 8'hff);
    wait_aux_clear();
    rd_chk(1'b1, 1'b1, 8'h46);
    chk_out("software reset", 16'h1, 16'(software_core_reset_o));
    $display("test buffer clear done");
    // mode change trigger and mode field
    wr(1'b1, 1'b1, 8'h45, 8'he8);
    #1;
    chk_out("mode_change_start_o", 16'h1, 16'(mode_change_start_o));
    chk_out("flash_op_mode_o", 16'h0006, 16'(flash_op_mode_o));
    chk_out("write enable", 16'h1, 16'(flash_write_enable_flag_o));
    @(posedge ref_clk_i);
    mode_done_i <= 1'b1;
    @(posedge ref_clk_i);
    mode_done_i <= 1'b0;
    rd(1'b1, 1'b1, 8'h45);
    chk_reg("op control", 8'he0, rv);
    $display("test mode change done");
    tally_and_finish();
  end
endmodule : testbench
